//--- otr_avg16.sv
// sixteen-sample rolling average with clear
// assumes tick_i is a one-cycle strobe on the same clock
`timescale 1ns/100ps
`default_nettype none
module otr_avg16
   import otr_pkg::*;
#(
   parameter int W = 8
)(
   // clock and reset
   input  wire logic         clock_i,
   input  wire logic         srst_i,
   // samples
   input  wire logic         clear_i,
   input  wire logic         tick_i,
   input  wire logic [W-1:0] sample_i,
   // result
   output logic      [W-1:0] avg_o
);
   logic [W-1:0]               win [OTR_AVG_DEPTH];
   logic [3:0]                 idx;
   logic [W+OTR_AVG_SHIFT-1:0] sum;

   // window slots; a clear fills them with zero so early averages count zeros
   always_ff @(posedge clock_i)
   begin
      if (srst_i || clear_i)
      begin
         for (int i = 0; i < OTR_AVG_DEPTH; i++)
            win[i] <= '0;
         idx <= 4'h0;
      end
      else if (tick_i)
      begin
         win[idx] <= sample_i;
         idx      <= idx + 4'h1;
      end
   end

   // running sum avoids a 16-input adder every refresh
   always_ff @(posedge clock_i)
   begin
      if (srst_i || clear_i)
         sum <= '0;
      else if (tick_i)
         sum <= sum + (W+OTR_AVG_SHIFT)'(sample_i) - (W+OTR_AVG_SHIFT)'(win[idx]);
   end

   // divide by the window depth
   assign avg_o = sum[W+OTR_AVG_SHIFT-1:OTR_AVG_SHIFT];

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   chk_avg_cleared: assert property (clear_i |=> (sum == '0 && idx == 4'h0))
      else $error("average not cleared by bus switch opening");
   chk_avg_accumulate: assert property ((tick_i && !clear_i) |=>
                        sum == $past(sum) + (W+OTR_AVG_SHIFT)'($past(sample_i))
                               - (W+OTR_AVG_SHIFT)'($past(win[idx])))
      else $error("rolling sum did not replace oldest sample");

endmodule
`default_nettype wire

//--- otr_i2c_master.sv
// serial bus master model reading telemetry from the readout slave
// assumes the bench resolves the open-drain data wire; pins move on falling clock
`timescale 1ns/100ps
`default_nettype none
module otr_i2c_master
   import otr_pkg::*;
(
   // clock
   input  wire logic clock_i,
   // bus pins
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_n_o
);
   // idle bus: both lines released high
   initial
   begin
      scl_o      = 1'b1;
      sda_oe_n_o = 1'b1;
   end

   // quarter bit of 4 cycles keeps each scl phase at 8 cycles, above the minimum
   task automatic q;
      repeat (4) @(negedge clock_i);
   endtask

   task automatic start;
      sda_oe_n_o = 1'b1;
      scl_o = 1'b1;
      q;
      sda_oe_n_o = 1'b0;
      q;
      scl_o = 1'b0;
      q;
   endtask

   task automatic stop;
      sda_oe_n_o = 1'b0;
      q;
      scl_o = 1'b1;
      q;
      sda_oe_n_o = 1'b1;
      q;
   endtask

   // data held over the whole high phase of scl
   task automatic bit_out(input logic b);
      sda_oe_n_o = b;
      q;
      scl_o = 1'b1;
      q;
      q;
      scl_o = 1'b0;
      q;
   endtask

   // sampled mid-way through the high phase, well after the slave's delay
   task automatic bit_in(output logic b);
      sda_oe_n_o = 1'b1;
      q;
      scl_o = 1'b1;
      q;
      b = sda_i;
      q;
      scl_o = 1'b0;
      q;
   endtask

   task automatic byte_w(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
         bit_out(d[i]);
      bit_in(b);
      ack = ~b;
   endtask

   task automatic byte_r(output logic [7:0] d, input logic last);
      logic b;
      for (int i = 0; i < 8; i++)
      begin
         bit_in(b);
         d = {d[6:0], b};
      end
      bit_out(last);
   endtask

   // address byte alone, to see whether the slave answers
   task automatic probe(input logic [7:0] a, output logic ack);
      start;
      byte_w(a, ack);
      stop;
   endtask

   // telemetry address into the read pointer
   task automatic set_ptr(input logic [7:0] t, output logic ack);
      logic a1, a2, a3;
      start;
      byte_w({OTR_DEV_ADDR, 1'b0}, a1);
      byte_w(OTR_CMD_READ_PTR, a2);
      byte_w(t, a3);
      stop;
      ack = a1 & a2 & a3;
   endtask

   // two bytes, low first; nack on the last ends the read
   task automatic get_word(output logic [15:0] w, output logic ack);
      logic [7:0] lo, hi;
      start;
      byte_w({OTR_DEV_ADDR, 1'b1}, ack);
      byte_r(lo, 1'b0);
      byte_r(hi, 1'b1);
      stop;
      w = {hi, lo};
   endtask
endmodule
`default_nettype wire

//--- otr_meas.sv
// refresh timer and capture of instantaneous converter codes
// assumes converter codes are stable on the clock that samples them
`timescale 1ns/100ps
`default_nettype none
module otr_meas
   import otr_pkg::*;
#(
   parameter int SAMPLE_CYCLES = OTR_SAMPLE_CYCLES
)(
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   // converter codes
   input  wire logic [7:0]  current_count_i,
   input  wire logic [11:0] voltage_code_i,
   // fresh samples
   otr_sample_if.src        smp
);
   localparam logic [15:0] LAST = 16'(SAMPLE_CYCLES - 1);

   logic [15:0] tmr;
   logic [15:0] gap;
   logic        seen;

   // free-running refresh period counter
   always_ff @(posedge clock_i)
   begin
      if (srst_i || tmr == LAST)
         tmr <= 16'h0000;
      else
         tmr <= tmr + 16'h0001;
   end

   // capture both codes together so they always belong to one refresh
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         smp.tick <= 1'b0;
         smp.cur  <= 8'h00;
         smp.volt <= 12'h000;
      end
      else
      begin
         smp.tick <= (tmr == LAST);
         if (tmr == LAST)
         begin
            // codes above full scale clip to 100 percent
            smp.cur  <= (current_count_i > OTR_CUR_FULL) ? OTR_CUR_FULL : current_count_i;
            smp.volt <= voltage_code_i;
         end
      end
   end

   // spacing helper for the refresh check
   always_ff @(posedge clock_i)
   begin
      if (srst_i || smp.tick)
         gap <= 16'h0000;
      else
         gap <= gap + 16'h0001;
      if (srst_i)
         seen <= 1'b0;
      else if (smp.tick)
         seen <= 1'b1;
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   chk_refresh_spacing: assert property ((smp.tick && seen) |-> gap == LAST)
      else $error("telemetry refresh spacing wrong");
   chk_current_clip: assert property ((tmr == LAST && current_count_i > OTR_CUR_FULL)
                                      |=> smp.cur == OTR_CUR_FULL)
      else $error("current code not clipped to full scale");

endmodule
`default_nettype wire

//--- otr_pkg.sv
// constants, types and encoding helpers for the output telemetry readout
// assumes one 125 MHz clock; analog converters deliver codes on that clock
package otr_pkg;

   // serial bus identity and command
   localparam logic [6:0]  OTR_DEV_ADDR     = 7'h18;
   localparam logic [7:0]  OTR_CMD_READ_PTR = 8'h80;
   localparam logic [7:0]  OTR_PTR_RESET    = 8'h00;

   // telemetry addresses selected through the read pointer
   localparam logic [7:0]  OTR_TLM_CUR      = 8'h0E;
   localparam logic [7:0]  OTR_TLM_VOLT     = 8'h12;
   localparam logic [7:0]  OTR_TLM_AVG_CUR  = 8'h58;
   localparam logic [7:0]  OTR_TLM_AVG_VOLT = 8'h5A;

   // converter widths and scaling
   localparam int          OTR_CUR_W        = 8;
   localparam int          OTR_VOLT_W       = 12;
   localparam logic [7:0]  OTR_CUR_FULL     = 8'h80;
   localparam int          OTR_SENSE_TH_UV  = 32000;
   localparam int          OTR_CUR_STEPS    = 128;
   localparam int          OTR_CUR_LSB_NV   = OTR_SENSE_TH_UV * 1000 / OTR_CUR_STEPS;
   localparam int          OTR_PAR_BIT      = 15;

   // rolling average window
   localparam int          OTR_AVG_DEPTH    = 16;
   localparam int          OTR_AVG_SHIFT    = 4;

   // refresh timing
   localparam int          OTR_CLK_PERIOD_NS    = 8;
   localparam int          OTR_SAMPLE_PERIOD_NS = 100000;
   localparam int          OTR_SAMPLE_CYCLES    = OTR_SAMPLE_PERIOD_NS / OTR_CLK_PERIOD_NS;

   // serial slave states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_AACK  = 3'b010,
      ST_WRITE = 3'b011,
      ST_WACK  = 3'b100,
      ST_READ  = 3'b101,
      ST_RACK  = 3'b110
   } otr_i2c_state_t;

   // current word: count in low byte, parity flag in top bit
   function automatic logic [15:0] otr_cur_word(input logic [7:0] count);
      otr_cur_word = {^count, 7'h00, count};
   endfunction

   // voltage word: 12-bit code, upper bits zero
   function automatic logic [15:0] otr_volt_word(input logic [11:0] code);
      otr_volt_word = {4'h0, code};
   endfunction

endpackage

//--- otr_sample_if.sv
// sample strobe and fresh converter codes between the timer and the readout
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface otr_sample_if;
   logic        tick;
   logic [7:0]  cur;
   logic [11:0] volt;
   modport src (output tick, output cur, output volt);
   modport snk (input tick, input cur, input volt);
endinterface
`default_nettype wire

//--- otr_top.sv
// output telemetry readout: refresh, rolling averages and serial slave
// assumes scl and sda come from pins; other inputs are on this clock
//
// Contract
// - instantaneous load current readable at telemetry address 0x0E, relative to threshold.
// - current converter full scale is 128 counts, meaning 100 percent threshold.
// - current count scales to the sense-resistor threshold voltage, not amperes.
// - one current count weighs 0.25 mV, i.e. 32 mV over 128 steps.
// - current high byte carries parity bit; master strips it before use.
// - two rolling 16-sample averages, of output current and output voltage.
// - opening the bus switch clears both averages and restarts accumulation.
// - averages use the same resolution and encoding as instantaneous registers.
// - voltage and current readings refresh every 100 microseconds.
// - serial interface silent while controller supply is below its reset level.
// - every telemetry value returns as two bytes, low byte first.
// - device answers at 7-bit address 0x18; bytes 0x30 write, 0x31 read.
`timescale 1ns/100ps
`default_nettype none
module otr_top
   import otr_pkg::*;
#(
   parameter int SAMPLE_CYCLES = OTR_SAMPLE_CYCLES
)(
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   // serial bus pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n_o,
   // converter codes
   input  wire logic [7:0]  current_count_i,
   input  wire logic [11:0] voltage_code_i,
   // supervision
   input  wire logic        bus_switch_open_i,
   input  wire logic        below_controller_supply_reset_level_i
);

   otr_sample_if smp ();

   logic [15:0]     output_current_reading;
   logic [15:0]     output_voltage_reading;
   logic [7:0]      avg_cur;
   logic [11:0]     avg_volt;
   logic [7:0]      read_pointer_register;
   otr_i2c_state_t  state;
   logic [3:0]      bit_cnt;
   logic [7:0]      shift;
   logic [7:0]      tx_byte;
   logic [15:0]     tx_word;
   logic            rw;
   logic            nack;
   logic            byte_hi;
   logic            wr_first;
   logic            cmd_ptr;
   logic            sda_low;
   logic            scl_s1, scl_s2, scl_d;
   logic            sda_s1, sda_s2, sda_d;
   logic            scl_rise, scl_fall, start_seen, stop_seen, mute;

   // refresh timer and capture
   otr_meas #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_meas (
      .clock_i         (clock_i),
      .srst_i          (srst_i),
      .current_count_i (current_count_i),
      .voltage_code_i  (voltage_code_i),
      .smp             (smp)
   );

   // rolling averages, held clear while the bus switch is open
   otr_avg16 #(.W(OTR_CUR_W)) u_avg_cur (
      .clock_i  (clock_i),
      .srst_i   (srst_i),
      .clear_i  (bus_switch_open_i),
      .tick_i   (smp.tick),
      .sample_i (smp.cur),
      .avg_o    (avg_cur)
   );

   otr_avg16 #(.W(OTR_VOLT_W)) u_avg_volt (
      .clock_i  (clock_i),
      .srst_i   (srst_i),
      .clear_i  (bus_switch_open_i),
      .tick_i   (smp.tick),
      .sample_i (smp.volt),
      .avg_o    (avg_volt)
   );

   // instantaneous readings; count is a fraction of the sense threshold,
   // each step being the threshold voltage over the full-scale count
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         output_current_reading <= 16'h0000;
         output_voltage_reading <= 16'h0000;
      end
      else if (smp.tick)
      begin
         output_current_reading <= otr_cur_word(smp.cur);
         output_voltage_reading <= otr_volt_word(smp.volt);
      end
   end

   // telemetry selection; unmapped addresses read as zero
   function automatic logic [15:0] tlm_word(input logic [7:0] addr);
      case (addr)
         OTR_TLM_CUR:      tlm_word = output_current_reading;
         OTR_TLM_VOLT:     tlm_word = output_voltage_reading;
         OTR_TLM_AVG_CUR:  tlm_word = otr_cur_word(avg_cur);
         OTR_TLM_AVG_VOLT: tlm_word = otr_volt_word(avg_volt);
         default:          tlm_word = 16'h0000;
      endcase
   endfunction

   // pin synchronisers plus one delayed copy for edge detection
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         {scl_s1, scl_s2, scl_d} <= 3'h7;
         {sda_s1, sda_s2, sda_d} <= 3'h7;
      end
      else
      begin
         scl_s1 <= scl_i;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   // bus events
   assign scl_rise   = scl_s2 & ~scl_d;
   assign scl_fall   = ~scl_s2 & scl_d;
   assign start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_seen  = scl_s2 & scl_d & ~sda_d & sda_s2;
   assign mute       = below_controller_supply_reset_level_i;

   // serial slave; a start anywhere restarts the address phase
   always_ff @(posedge clock_i)
   begin
      if (srst_i || mute)
      begin
         state    <= ST_IDLE;
         sda_low  <= 1'b0;
         bit_cnt  <= 4'h0;
         shift    <= 8'h00;
         tx_byte  <= 8'h00;
         tx_word  <= 16'h0000;
         rw       <= 1'b0;
         nack     <= 1'b0;
         byte_hi  <= 1'b0;
         wr_first <= 1'b0;
         cmd_ptr  <= 1'b0;
      end
      else if (start_seen)
      begin
         state    <= ST_ADDR;
         sda_low  <= 1'b0;
         bit_cnt  <= 4'h0;
         wr_first <= 1'b1;
         cmd_ptr  <= 1'b0;
      end
      else if (stop_seen)
      begin
         state   <= ST_IDLE;
         sda_low <= 1'b0;
      end
      else
      begin
         case (state)
            ST_ADDR, ST_WRITE:
            begin
               if (scl_rise)
               begin
                  shift   <= {shift[6:0], sda_s2};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               else if (scl_fall && bit_cnt == 4'h8)
               begin
                  bit_cnt <= 4'h0;
                  if (state == ST_ADDR)
                  begin
                     // foreign address: drop off the bus until the next start
                     if (shift[7:1] == OTR_DEV_ADDR)
                     begin
                        state   <= ST_AACK;
                        sda_low <= 1'b1;
                        rw      <= shift[0];
                        byte_hi <= 1'b0;
                        tx_word <= tlm_word(read_pointer_register);
                     end
                     else
                        state <= ST_IDLE;
                  end
                  else
                  begin
                     // other command bytes are acknowledged and ignored
                     state    <= ST_WACK;
                     sda_low  <= 1'b1;
                     wr_first <= 1'b0;
                     if (wr_first)
                        cmd_ptr <= (shift == OTR_CMD_READ_PTR);
                     else
                        cmd_ptr <= 1'b0; // bytes after the pointer leave it alone
                  end
               end
            end
            ST_AACK:
            begin
               if (scl_fall)
               begin
                  if (rw)
                  begin
                     state   <= ST_READ;
                     tx_byte <= tx_word[7:0];
                     sda_low <= ~tx_word[7];
                     bit_cnt <= 4'h1;
                  end
                  else
                  begin
                     state   <= ST_WRITE;
                     sda_low <= 1'b0;
                  end
               end
            end
            ST_WACK:
            begin
               if (scl_fall)
               begin
                  state   <= ST_WRITE;
                  sda_low <= 1'b0;
               end
            end
            ST_READ:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt == 4'h8)
                  begin
                     state   <= ST_RACK;
                     sda_low <= 1'b0;
                     bit_cnt <= 4'h0;
                     byte_hi <= ~byte_hi;
                  end
                  else
                  begin
                     tx_byte <= {tx_byte[6:0], 1'b0};
                     sda_low <= ~tx_byte[6];
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            ST_RACK:
            begin
               if (scl_rise)
                  nack <= sda_s2;
               else if (scl_fall)
               begin
                  if (nack)
                     state <= ST_IDLE;
                  else
                  begin
                     // low byte then high byte, wrapping if read goes on
                     state   <= ST_READ;
                     tx_byte <= byte_hi ? tx_word[15:8] : tx_word[7:0];
                     sda_low <= byte_hi ? ~tx_word[15] : ~tx_word[7];
                     bit_cnt <= 4'h1;
                  end
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // read pointer: the byte right after the pointer command
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         read_pointer_register <= OTR_PTR_RESET;
      else if (!mute && !start_seen && !stop_seen && state == ST_WRITE && scl_fall
               && bit_cnt == 4'h8 && !wr_first && cmd_ptr)
         read_pointer_register <= shift;
   end

   // open-drain data pin: enable low only while pulling low
   assign sda_o      = 1'b0;
   assign sda_oe_n_o = ~sda_low;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   sequence s_addr_done;
      !mute && !start_seen && !stop_seen && state == ST_ADDR && scl_fall && bit_cnt == 4'h8;
   endsequence

   sequence s_read_begin;
      !mute && !start_seen && !stop_seen && state == ST_AACK && scl_fall && rw;
   endsequence

   chk_addr_match: assert property (s_addr_done |=>
                   ((state == ST_AACK) == (($past(shift) & 8'hFE) == {OTR_DEV_ADDR, 1'b0})))
      else $error("address acknowledge does not match device address");
   chk_low_first: assert property (s_read_begin |=>
                   (tx_byte == tx_word[7:0] && sda_oe_n_o == tx_word[7]))
      else $error("read did not start with low byte");
   chk_current_select: assert property ((s_addr_done ##0 shift[7:1] == OTR_DEV_ADDR
                       ##0 read_pointer_register == OTR_TLM_CUR)
                       |=> tx_word == $past(output_current_reading))
      else $error("current address did not select current reading");
   chk_parity_flag: assert property (smp.tick |=>
                    (output_current_reading[7:0] == $past(smp.cur)
                    && output_current_reading[OTR_PAR_BIT] == ^output_current_reading[7:0]))
      else $error("current reading parity flag wrong");
   chk_full_scale: assert property (output_current_reading[7:0] <= OTR_CUR_FULL)
      else $error("current reading above full scale");
   chk_supply_mute: assert property (mute |=>
                    (sda_oe_n_o && state == ST_IDLE) ##1 sda_oe_n_o)
      else $error("serial bus active below supply reset level");
   chk_pointer_load: assert property (
                     (state == ST_WRITE && scl_fall && bit_cnt == 4'h8 && !wr_first
                     && cmd_ptr && !mute && !start_seen && !stop_seen)
                     |=> read_pointer_register == $past(shift))
      else $error("read pointer not loaded");
   chk_avg_encoding: assert property ((s_addr_done ##0 shift[7:1] == OTR_DEV_ADDR
                     ##0 read_pointer_register == OTR_TLM_AVG_CUR)
                     |=> tx_word == {^$past(avg_cur), 7'h00, $past(avg_cur)})
      else $error("averaged current encoding differs");

endmodule
`default_nettype wire

//--- output_telemetry_readout_test.sv
// self-checking bench for the output telemetry readout
// assumes the master model above and pull-ups on both bus wires
`timescale 1ns/100ps
`default_nettype none
module output_telemetry_readout_test
   import otr_pkg::*;
;
   localparam int SC = 400; // short refresh period for simulation

   logic        clock_i, srst_i, sda, dut_sda, dut_oe_n, m_oe_n, scl;
   logic [7:0]  cur;
   logic [11:0] volt;
   logic        sw_open, low_sup;
   int          bad_count, check_count;

   // pull-up wire: low when either party enables its driver
   assign sda = m_oe_n & (dut_oe_n | dut_sda);

   otr_top #(.SAMPLE_CYCLES(SC)) i_dut (
      .clock_i(clock_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda),
      .sda_o(dut_sda), .sda_oe_n_o(dut_oe_n),
      .current_count_i(cur), .voltage_code_i(volt),
      .bus_switch_open_i(sw_open), .below_controller_supply_reset_level_i(low_sup));

   otr_i2c_master i_master (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));

   initial
   begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // current word: count low, XOR of its bits as parity flag in bit 15
   function automatic logic [15:0] cur_exp(input logic [7:0] c);
      return {^c, 7'h00, c};
   endfunction

   task automatic rd(input logic [7:0] t, output logic [15:0] w);
      logic a;
      i_master.set_ptr(t, a);
      check("pointer ack", {15'h0, a}, 16'h0001);
      i_master.get_word(w, a);
      check("read ack", {15'h0, a}, 16'h0001);
   endtask

   // full scale at 128, codes above clipped, parity on the high byte
   task automatic t_current;
      logic [7:0]  tab [5] = '{8'h00, 8'h40, 8'h7F, 8'h80, 8'hC8};
      logic [15:0] w;
      check("idle data enable", {15'h0, dut_oe_n}, 16'h0001);
      for (int i = 0; i < 5; i++)
      begin
         cur = tab[i];
         cyc(SC + 10);
         rd(OTR_TLM_CUR, w);
         check("current", w, cur_exp(tab[i] > 8'h80 ? 8'h80 : tab[i]));
         check("current count", {8'h00, w[7:0]}, {8'h00, tab[i] > 8'h80 ? 8'h80 : tab[i]});
      end
   endtask

   // byte order shows since both bytes differ
   task automatic t_voltage;
      logic [15:0] w;
      volt = 12'hABC;
      cyc(SC + 10);
      rd(OTR_TLM_VOLT, w);
      check("voltage", w, 16'h0ABC);
   endtask

   // cleared while switch open, partial sums after, full window later
   task automatic t_average;
      logic [15:0] w;
      logic        ok;
      sw_open = 1'b1;
      cur = 8'h70;
      volt = 12'h100;
      cyc(2 * SC);
      rd(OTR_TLM_AVG_CUR, w);
      check("avg current open", w, 16'h0000);
      sw_open = 1'b0;
      rd(OTR_TLM_AVG_CUR, w);
      // parity stripped; one or two samples of 0x70 over sixteen
      ok = (w[14:0] == 15'h0007) || (w[14:0] == 15'h000E);
      check("avg current partial", {15'h0, ok}, 16'h0001);
      cyc(17 * SC);
      rd(OTR_TLM_AVG_CUR, w);
      check("avg current full", w, cur_exp(8'h70));
      rd(OTR_TLM_AVG_VOLT, w);
      check("avg voltage full", w, 16'h0100);
      sw_open = 1'b1;
      cyc(10);
      rd(OTR_TLM_AVG_VOLT, w);
      check("avg voltage open", w, 16'h0000);
      sw_open = 1'b0;
   endtask

   // no answer on low supply or a foreign address
   task automatic t_refuse;
      logic a;
      low_sup = 1'b1;
      cyc(2);
      i_master.probe({OTR_DEV_ADDR, 1'b0}, a);
      check("ack on low supply", {15'h0, a}, 16'h0000);
      low_sup = 1'b0;
      cyc(4);
      i_master.probe(8'h32, a);
      check("ack foreign address", {15'h0, a}, 16'h0000);
      i_master.probe(8'h30, a);
      check("ack own address", {15'h0, a}, 16'h0001);
   endtask

   // main sequence: reset held 8 cycles, inputs at falling edge
   initial
   begin
      srst_i = 1'b1;
      cur = 8'h00;
      volt = 12'h000;
      sw_open = 1'b0;
      low_sup = 1'b0;
      cyc(8);
      srst_i = 1'b0;
      cyc(4);
      t_current;
      t_voltage;
      t_average;
      t_refuse;
      end_of_test;
   end

   // watchdog well beyond the expected run of about 21k cycles
   initial
   begin
      repeat (60000) @(posedge clock_i);
      bad_count++;
      end_of_test;
   end
endmodule
`default_nettype wire
